//--- verilog/pdc_defines.vh
/*
 * Constants for the deadtime correction select block: APB offsets, field
 * positions, reset values and correction method codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH

// APB register byte offsets
`define PDC_OFS_CTRL        12'h000
`define PDC_OFS_SAMPLE      12'h004
`define PDC_OFS_STATUS      12'h008

// Control register fields
`define PDC_CTRL_METHOD_LO  0
`define PDC_CTRL_METHOD_HI  1
`define PDC_CTRL_POL_LO     4
`define PDC_CTRL_POL_HI     6
`define PDC_CTRL_DIR_LO     8
`define PDC_CTRL_DIR_HI     10
`define PDC_CTRL_WMASK      32'h0000_0773
`define PDC_CTRL_RESET      32'h0000_0000

// Correction methods
`define PDC_METHOD_NONE     2'h0
`define PDC_METHOD_MANUAL   2'h1
`define PDC_METHOD_DEADTIME 2'h2
`define PDC_METHOD_CYCLE    2'h3

`define PDC_PAIRS           3

`endif

//--- verilog/pdc_pair.v
/*
 * One complementary pair: current sense sampling and value register select.
 * Assumes cycle_end/half_cycle/deadtime_end strobes one cycle wide on
 * sys_clk and a sense input already synchronised.
 */
`default_nettype none
`include "pdc_defines.vh"

module pdc_pair (
  input  wire       sys_clk,        // Core clock
  input  wire       rst_b,          // Async reset, active low
  input  wire [1:0] method,         // Correction method
  input  wire       pol_bit,        // Manual odd/even select, live value
  input  wire       dir_enable,     // Direction correction enable
  input  wire       count_down,     // Counter direction, 1 = down
  input  wire       center_aligned, // Center aligned operation
  input  wire       gen_start,      // Generator enable rising edge
  input  wire       cycle_end,      // End of PWM cycle strobe
  input  wire       half_cycle,     // Half cycle strobe
  input  wire       top_active,     // Top output active
  input  wire       bot_active,     // Bottom output active
  input  wire       dt_end_top,     // End of deadtime before top
  input  wire       dt_end_bot,     // End of deadtime before bottom
  input  wire       sense,          // Synchronised sense, low = positive
  output reg        sel_odd_reg,    // 1 selects odd value register
  output reg  [1:0] dt_sample_reg   // Deadtime samples {bottom, top}
);

  reg pol_buf_reg;
  reg sense_latch_reg;
  reg sense_buf_reg;
  reg dir_en_buf_reg;
  reg sel_next;
  wire point_sample;

  assign point_sample = center_aligned ? half_cycle : cycle_end;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pol_buf_reg     <= 1'b0;
      sense_latch_reg <= 1'b1;
      sense_buf_reg   <= 1'b1;
      dir_en_buf_reg  <= 1'b0;
      dt_sample_reg   <= 2'h0;
      // Matches method 00 so no select glitch follows reset
      sel_odd_reg     <= 1'b0;
    end else begin
      // Each end of deadtime overwrites its sample
      if (dt_end_top)
        dt_sample_reg[0] <= sense;
      if (dt_end_bot)
        dt_sample_reg[1] <= sense;
      if (gen_start) begin
        sense_latch_reg <= 1'b1;
        sense_buf_reg   <= 1'b1;
      end else if (method == `PDC_METHOD_DEADTIME) begin
        if (!top_active && !bot_active)
          sense_latch_reg <= sense;
      end else if (method == `PDC_METHOD_CYCLE) begin
        if (point_sample)
          sense_latch_reg <= sense;
      end
      if (cycle_end) begin
        pol_buf_reg    <= pol_bit;
        dir_en_buf_reg <= dir_enable;
        // A first enable in the same cycle keeps the odd start value
        if (!gen_start)
          sense_buf_reg <= sense_latch_reg;
      end
      sel_odd_reg <= sel_next;
    end
  end

  always @* begin
    sel_next = sel_odd_reg;
    case (method)
      `PDC_METHOD_MANUAL: begin
        if (dir_en_buf_reg)
          sel_next = count_down;
        else
          sel_next = pol_buf_reg;
      end
      `PDC_METHOD_DEADTIME,
      `PDC_METHOD_CYCLE: begin
        sel_next = sense_buf_reg;
      end
      default: begin
        sel_next = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

//--- verilog/pdc_top.v
/*
 * Deadtime distortion correction select for three complementary PWM pairs,
 * with APB register access to method, manual select and sample bits.
 * Assumes counter, deadtime generator and outputs live outside; their
 * strobes arrive on sys_clk. Sense pins are asynchronous.
 */
// The register addresses and register access over APB are this design's own decisions.
// Overview of operation
// - A two-bit method field picks none, manual, deadtime or cycle-point.
// - Cycle-point method samples at half cycle centred, cycle end edged.
// - Deadtime method latches sense only while both pair outputs are off.
// - Cycle-point method samples every cycle even at 0% or 100% duty.
// - In manual mode select bit 0 picks the even and 1 the odd register.
// - Direction enable 0 uses the manual bit, 1 uses counter direction.
// - Manual select bits apply only at the end of the current PWM cycle.
// - Sense is sampled at each deadtime end into two readable bits.
// - Low sampled sense picks even, high picks odd; inputs 0..2 map A..C.
// - Latched sense is buffered so one register serves a whole cycle.
// - On first enable in a sense method the odd registers are used.
// - Outputs 0, 2, 4 are top and 1, 3, 5 are bottom channels.
// - Method 00 applies no correction and leaves sense pins free.
// - Direction correction uses even counting up and odd counting down.
`default_nettype none
`include "pdc_defines.vh"

module pdc_top (
  input  wire        sys_clk,          // Core clock, 100 MHz
  input  wire        rst_b,            // Async reset, active low
  input  wire        psel,             // APB select
  input  wire        penable,          // APB enable
  input  wire        pwrite,           // APB write
  input  wire [11:0] paddr,            // APB byte address
  input  wire [31:0] pwdata,           // APB write data
  input  wire [3:0]  pstrb,            // APB byte strobes
  output reg  [31:0] prdata,           // APB read data
  output reg         pready,           // APB ready
  output reg         pslverr,          // APB error, unmapped address
  input  wire        generator_enable, // Generator enable bit
  input  wire        center_aligned,   // Center aligned operation
  input  wire        count_down,       // Counter counting down
  input  wire        cycle_end,        // End of PWM cycle strobe
  input  wire        half_cycle,       // Half cycle strobe
  input  wire [5:0]  pwm_active,       // Channel active, even = top
  input  wire [2:0]  dt_end_top,       // Deadtime end before top output
  input  wire [2:0]  dt_end_bot,       // Deadtime end before bottom output
  input  wire [2:0]  current_sense_in, // Sense pins a..c, active low
  output reg  [2:0]  sel_odd,          // 1 = odd value register per pair
  output reg  [1:0]  correction_method // Buffered method to generator
);

  reg  [31:0] ctrl_reg;
  reg  [2:0]  sense_meta_reg;
  reg  [2:0]  sense_sync_reg;
  reg         gen_en_d_reg;
  wire [2:0]  sel_odd_w;
  wire [5:0]  dt_sample_w;
  wire [1:0]  method_w;
  wire [2:0]  pol_w;
  wire [2:0]  dir_w;
  wire        gen_start;
  wire        acc;
  wire        hit_ctrl;
  wire        hit_sample;
  wire        hit_status;
  wire [31:0] wmask;

  assign method_w   = ctrl_reg[`PDC_CTRL_METHOD_HI:`PDC_CTRL_METHOD_LO];
  assign pol_w      = ctrl_reg[`PDC_CTRL_POL_HI:`PDC_CTRL_POL_LO];
  assign dir_w      = ctrl_reg[`PDC_CTRL_DIR_HI:`PDC_CTRL_DIR_LO];
  assign gen_start  = generator_enable & ~gen_en_d_reg;
  assign acc        = psel & penable & ~pready;
  assign hit_ctrl   = (paddr == `PDC_OFS_CTRL);
  assign hit_sample = (paddr == `PDC_OFS_SAMPLE);
  assign hit_status = (paddr == `PDC_OFS_STATUS);
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
                  {8{pstrb[0]}}} & `PDC_CTRL_WMASK;

  // Sense pins are asynchronous: two stages before any use
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sense_meta_reg <= 3'h7;
      sense_sync_reg <= 3'h7;
      gen_en_d_reg   <= 1'b0;
    end else begin
      sense_meta_reg <= current_sense_in;
      sense_sync_reg <= sense_meta_reg;
      gen_en_d_reg   <= generator_enable;
    end
  end

  // APB slave, one wait state: answer in the cycle after the first access
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `PDC_CTRL_RESET;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~(hit_ctrl | hit_sample | hit_status);
      prdata  <= 32'h0000_0000;
      if (acc && pwrite && hit_ctrl)
        ctrl_reg <= (ctrl_reg & ~wmask) | (pwdata & wmask);
      if (acc && !pwrite) begin
        if (hit_ctrl)
          prdata <= ctrl_reg;
        else if (hit_sample)
          prdata <= {26'h0, dt_sample_w};
        else if (hit_status)
          prdata <= {25'h0, sense_sync_reg, 1'b0, sel_odd_w};
      end
    end
  end

  // Outputs registered; method 00 frees the sense pins for other use
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_odd           <= 3'h0;
      correction_method <= 2'h0;
    end else begin
      sel_odd           <= sel_odd_w;
      correction_method <= method_w;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `PDC_PAIRS; g = g + 1) begin : pair
      // Channel 2g is top and 2g+1 is bottom of pair g
      pdc_pair u_pair (
        .sys_clk        (sys_clk),
        .rst_b          (rst_b),
        .method         (method_w),
        .pol_bit        (pol_w[g]),
        .dir_enable     (dir_w[g]),
        .count_down     (count_down),
        .center_aligned (center_aligned),
        .gen_start      (gen_start),
        .cycle_end      (cycle_end),
        .half_cycle     (half_cycle),
        .top_active     (pwm_active[2*g]),
        .bot_active     (pwm_active[2*g+1]),
        .dt_end_top     (dt_end_top[g]),
        .dt_end_bot     (dt_end_bot[g]),
        .sense          (sense_sync_reg[g]),
        .sel_odd_reg    (sel_odd_w[g]),
        .dt_sample_reg  (dt_sample_w[2*g+1:2*g])
      );
    end
  endgenerate

endmodule

`default_nettype wire

//--- test/pdc_sense_model.sv
/* Sensor model driving the sense pins.
   Assumes cur_neg is 1 where load current is negative. */
`default_nettype none
module pdc_sense_model (
  input  wire logic [2:0] cur_neg, // Negative current per pair
  output logic      [2:0] sense    // Sense pins, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  assign sense = cur_neg;
endmodule
`default_nettype wire

//--- test/pdc_top_checker.sv
/* Port assertions for pdc_top.
   Assumes one clock and the async reset. */
`default_nettype none
module pdc_top_checker (
  input wire logic        sys_clk,          // Clock
  input wire logic        rst_b,            // Reset
  input wire logic        psel,             // APB select
  input wire logic        penable,          // APB enable
  input wire logic [11:0] paddr,            // APB address
  input wire logic [31:0] prdata,           // APB read data
  input wire logic        pready,           // APB ready
  input wire logic        pslverr,          // APB error
  input wire logic        generator_enable, // Enable
  input wire logic        count_down,       // Direction
  input wire logic        cycle_end,        // Cycle end
  input wire logic [2:0]  sel_odd,          // Odd select
  input wire logic [1:0]  correction_method // Method copy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [4:0] hist_reg;
  // Recent causes that may move the selection
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      hist_reg <= 5'h00;
    else
      hist_reg <= {hist_reg[3:2], cycle_end | pready |
        (count_down != hist_reg[1]) | (generator_enable != hist_reg[0]),
        count_down, generator_enable};
  end
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_err_unmapped: assert property (pready &&
    !(paddr inside {12'h000, 12'h004, 12'h008}) |-> pslverr)
    else $error("no error on unmapped address");
  a_ok_mapped: assert property (pready &&
    (paddr inside {12'h000, 12'h004, 12'h008}) |-> !pslverr)
    else $error("error on mapped address");
  a_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("read data on error");
  // First enable while a sense method is selected
  sequence s_sense_enable;
    $rose(generator_enable) && correction_method[1];
  endsequence
  a_sel_cause: assert property (
    $changed(sel_odd) |-> |hist_reg[4:2])
    else $error("selection moved mid cycle");
  a_method_cause: assert property (
    $changed(correction_method) |-> |hist_reg[4:2])
    else $error("method moved without cause");
  a_first_odd: assert property (
    s_sense_enable |-> ##[1:4] sel_odd == 3'h7)
    else $error("no odd select on enable");
  a_none_even: assert property (
    (correction_method == 2'h0) [*4] |-> sel_odd == 3'h0)
    else $error("selection without method");
endmodule
bind pdc_top pdc_top_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .generator_enable(generator_enable),
  .count_down(count_down), .cycle_end(cycle_end), .sel_odd(sel_odd),
  .correction_method(correction_method));
`default_nettype wire

//--- test/pdc_top_test.sv
/* Self-checking bench for pdc_top.
   Assumes pdc_sense_model drives the sense pins. */
`default_nettype none
module pdc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, generator_enable = 1'b0, count_down = 1'b0;
  logic        center_aligned = 1'b0, cycle_end = 1'b0, half_cycle = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0]  pwm_active = 6'h00;
  logic [2:0]  dt_top = 3'h0, dt_bot = 3'h0, cur_neg = 3'h0, sense, sel_odd;
  logic [1:0]  correction_method;
  logic        pready, pslverr, er;
  int          fail_count = 0, compares = 0;
  always #5 sys_clk = ~sys_clk;
  pdc_sense_model u_sense (.cur_neg(cur_neg), .sense(sense));
  pdc_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .generator_enable(generator_enable), .center_aligned(center_aligned),
    .count_down(count_down), .cycle_end(cycle_end),
    .half_cycle(half_cycle), .pwm_active(pwm_active), .dt_end_top(dt_top),
    .dt_end_bot(dt_bot), .current_sense_in(sense), .sel_odd(sel_odd),
    .correction_method(correction_method));
  task end_of_test;
    $display("fail_count %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task settle;
    repeat (6) @(posedge sys_clk);
  endtask
  task cyc;
    @(posedge sys_clk);
    cycle_end <= 1'b1;
    @(posedge sys_clk);
    cycle_end <= 1'b0;
    settle();
  endtask
  task dt_pulse;
    @(posedge sys_clk);
    dt_top <= 3'h7;
    dt_bot <= 3'h7;
    @(posedge sys_clk);
    dt_top <= 3'h0;
    dt_bot <= 3'h0;
    settle();
  endtask
  task t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'hFFFFFFFF);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h773);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask
  task t_manual;
    apb(1'b1, 12'h000, 32'h051);
    settle();
    chk({29'h0, sel_odd}, 32'h0);
    chk({30'h0, correction_method}, 32'h1);
    cyc();
    chk({29'h0, sel_odd}, 32'h5);
    apb(1'b1, 12'h000, 32'h021);
    settle();
    chk({29'h0, sel_odd}, 32'h5);
    cyc();
    chk({29'h0, sel_odd}, 32'h2);
  endtask
  task t_dir;
    apb(1'b1, 12'h000, 32'h751);
    cyc();
    chk({29'h0, sel_odd}, 32'h0);
    count_down <= 1'b1;
    settle();
    chk({29'h0, sel_odd}, 32'h7);
  endtask
  task t_dead;
    apb(1'b1, 12'h000, 32'h002);
    cur_neg <= 3'b010;
    settle();
    dt_pulse();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0C);
    cyc();
    chk({29'h0, sel_odd}, 32'h2);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h22);
    pwm_active <= 6'h15;
    cur_neg <= 3'b101;
    settle();
    cyc();
    chk({29'h0, sel_odd}, 32'h2);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0C);
    dt_pulse();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h33);
  endtask
  task t_cycle;
    apb(1'b1, 12'h000, 32'h003);
    cyc();
    generator_enable <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk({29'h0, sel_odd}, 32'h7);
    center_aligned <= 1'b1;
    cur_neg <= 3'b010;
    settle();
    @(posedge sys_clk);
    half_cycle <= 1'b1;
    @(posedge sys_clk);
    half_cycle <= 1'b0;
    cur_neg <= 3'b000;
    cyc();
    chk({29'h0, sel_odd}, 32'h2);
    center_aligned <= 1'b0;
    cur_neg <= 3'b101;
    settle();
    cyc();
    cyc();
    chk({29'h0, sel_odd}, 32'h5);
    apb(1'b1, 12'h000, 32'h000);
    cyc();
    chk({29'h0, sel_odd}, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_manual();
    t_dir();
    t_dead();
    t_cycle();
    end_of_test();
  end
  initial begin
    #50000;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
